// ### src/sacr_top.sv
// serial slave register bank for analog front-end configuration
`timescale 1ns/1ps
module sacr_top (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            sdo_oe,
    output logic [1:0]      amp_gain_code,
    output logic [4:0]      phase_gain_step_code,
    output logic [2:0]      correction_gain_code,
    output logic            shunt_amp_run,
    output logic            shunt_ref_source,
    output logic [1:0]      shunt_gain_code,
    output logic            level_detect_rst_n
);
    import sacr_pkg::*;
    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    // cs_n travels inverted so the chain resets to deselected
    logic [2:0] pins_sync;
    logic       sclk_s;
    logic       cs_s;
    logic       sdi_s;

    sacr_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk       (clk),
        .rst_n     (rst_n),
        .async_in  ({sclk, ~cs_n, sdi}),
        .reset_val (3'h2),
        .sync_out  (pins_sync)
    );

    assign sclk_s = pins_sync[2];
    assign cs_s   = pins_sync[1];
    assign sdi_s  = pins_sync[0];
    // ****************************************************************
    // edge detection
    // ****************************************************************
    logic sclk_d_reg;
    logic sclk_d_next;
    logic cs_d_reg;
    logic cs_d_next;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_fall;
    always_comb begin
        sclk_d_next = sclk_s;
        cs_d_next   = cs_s;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_d_reg <= 1'h0;
            cs_d_reg   <= 1'h1;
        end else begin
            sclk_d_reg <= sclk_d_next;
            cs_d_reg   <= cs_d_next;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s & sclk_d_reg;
    assign cs_rise   = cs_s & ~cs_d_reg;
    assign cs_fall   = ~cs_s & cs_d_reg;
    // ****************************************************************
    // frame engine
    // ****************************************************************
    sacr_state_e state_reg;
    sacr_state_e state_next;
    logic [4:0]  cnt_reg;
    logic [4:0]  cnt_next;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic        rw_reg;
    logic        rw_next;
    logic [6:0]  addr_reg;
    logic [6:0]  addr_next;
    logic [7:0]  tx_reg;
    logic [7:0]  tx_next;
    logic [6:0]  addr_now;
    logic [7:0]  rd_data;
    logic        frame_ok;
    logic        commit_w;

    assign addr_now = {shift_reg[5:0], sdi_s};
    assign frame_ok = (state_reg == SACR_SHIFT) && (cnt_reg == FRAME_BITS) && cs_rise;
    assign commit_w = frame_ok && (rw_reg != RW_READ);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        rw_next    = rw_reg;
        addr_next  = addr_reg;
        tx_next    = tx_reg;
        case (state_reg)
            SACR_IDLE: begin
                if (cs_fall) begin
                    state_next = SACR_SHIFT;
                    cnt_next   = 5'h00;
                    shift_next = 16'h0000;
                end
            end
            SACR_SHIFT: begin
                if (cs_rise) begin
                    state_next = SACR_IDLE;
                end else if (sclk_rise) begin
                    if (cnt_reg == FRAME_BITS) begin
                        state_next = SACR_ERR;
                    end else begin
                        shift_next = {shift_reg[14:0], sdi_s};
                        cnt_next   = cnt_reg + 5'h01;
                        if (cnt_reg == HEADER_BITS - 5'h01) begin
                            rw_next   = shift_reg[6];
                            addr_next = addr_now;
                            tx_next   = rd_data;
                        end
                    end
                end
            end
            SACR_ERR: begin
                if (cs_rise) begin
                    state_next = SACR_IDLE;
                end
            end
            default: begin
                state_next = SACR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= SACR_IDLE;
            cnt_reg   <= 5'h00;
            shift_reg <= 16'h0000;
            rw_reg    <= 1'h0;
            addr_reg  <= 7'h00;
            tx_reg    <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            rw_reg    <= rw_next;
            addr_reg  <= addr_next;
            tx_reg    <= tx_next;
        end
    end
    // ****************************************************************
    // register bank
    // ****************************************************************
    logic [7:0] gain_reg;
    logic [7:0] gain_next;
    logic [7:0] phase_reg;
    logic [7:0] phase_next;
    logic [7:0] corr_reg;
    logic [7:0] corr_next;
    logic [7:0] shunt_reg;
    logic [7:0] shunt_next;
    logic [7:0] lvl_reg;
    logic [7:0] lvl_next;
    logic [7:0] wr_data;

    assign wr_data = shift_reg[7:0];

    always_comb begin
        gain_next  = gain_reg;
        phase_next = phase_reg;
        corr_next  = corr_reg;
        shunt_next = shunt_reg;
        lvl_next   = lvl_reg;
        if (commit_w) begin
            if (addr_reg == ADDR_DIFF_AMP_GAIN) begin
                gain_next = wr_data & MASK_DIFF_AMP_GAIN;
            end else if (addr_reg == ADDR_PHASE_ADJ_GAIN) begin
                phase_next = wr_data & MASK_PHASE_ADJ_GAIN;
            end else if (addr_reg == ADDR_CORR_GAIN) begin
                // prohibited codes are stored as sent; guarding them is the host's job
                corr_next = wr_data & MASK_CORR_GAIN;
            end else if (addr_reg == ADDR_SHUNT_CTRL) begin
                shunt_next = wr_data & MASK_SHUNT_CTRL;
            end else if (addr_reg == ADDR_LVL_RESET) begin
                lvl_next = wr_data & MASK_LVL_RESET;
            end
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        if (addr_now == ADDR_DIFF_AMP_GAIN) begin
            rd_data = gain_reg;
        end else if (addr_now == ADDR_PHASE_ADJ_GAIN) begin
            rd_data = phase_reg;
        end else if (addr_now == ADDR_CORR_GAIN) begin
            rd_data = corr_reg;
        end else if (addr_now == ADDR_SHUNT_CTRL) begin
            rd_data = shunt_reg;
        end else if (addr_now == ADDR_LVL_RESET) begin
            rd_data = lvl_reg;
        end else begin
            rd_data = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gain_reg  <= REG_RESET_VAL;
            phase_reg <= REG_RESET_VAL;
            corr_reg  <= REG_RESET_VAL;
            shunt_reg <= REG_RESET_VAL;
            lvl_reg   <= REG_RESET_VAL;
        end else begin
            gain_reg  <= gain_next;
            phase_reg <= phase_next;
            corr_reg  <= corr_next;
            shunt_reg <= shunt_next;
            lvl_reg   <= lvl_next;
        end
    end
    // ****************************************************************
    // analog control outputs
    // ****************************************************************
    // amplifier gain code
    assign amp_gain_code        = gain_reg[1:0];
    assign phase_gain_step_code = phase_reg[4:0];
    assign correction_gain_code = corr_reg[2:0];
    assign shunt_amp_run        = shunt_reg[SHUNT_RUN_BIT];
    assign shunt_ref_source     = shunt_reg[SHUNT_REF_BIT];
    assign shunt_gain_code      = shunt_reg[1:0];
    assign level_detect_rst_n   = lvl_reg[LVL_RESET_BIT];
    // ****************************************************************
    // serial data out
    // ****************************************************************
    logic sdo_reg;
    logic sdo_next;
    logic sdo_oe_reg;
    logic sdo_oe_next;

    always_comb begin
        sdo_next = sdo_reg;
        sdo_oe_next = ~cs_s;
        if (state_reg != SACR_SHIFT) begin
            sdo_next = 1'h0;
        end else if (sclk_fall && (cnt_reg >= HEADER_BITS) && (cnt_reg < FRAME_BITS)) begin
            sdo_next = (rw_reg == RW_READ) ? tx_reg[~cnt_reg[2:0]] : 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sdo_reg    <= 1'h0;
            sdo_oe_reg <= 1'h0;
        end else begin
            sdo_reg    <= sdo_next;
            sdo_oe_reg <= sdo_oe_next;
        end
    end

    assign sdo    = sdo_reg;
    assign sdo_oe = sdo_oe_reg;
    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence seq_write_to(logic [6:0] a);
        commit_w && (addr_reg == a);
    endsequence
    sequence seq_bad_end;
        cs_rise && !frame_ok;
    endsequence
    AST_RESET_CLEAR: assert property (
        $rose(rst_n) |-> (gain_reg == REG_RESET_VAL) && (shunt_reg == REG_RESET_VAL)
            && (lvl_reg == REG_RESET_VAL) && (phase_reg == REG_RESET_VAL)
            && (corr_reg == REG_RESET_VAL))
        else $error("register not clear after reset");
    AST_RSVD_ZERO: assert property (
        ((gain_reg & ~MASK_DIFF_AMP_GAIN) == 8'h00) && ((shunt_reg & ~MASK_SHUNT_CTRL) == 8'h00)
            && ((phase_reg & ~MASK_PHASE_ADJ_GAIN) == 8'h00)
            && ((corr_reg & ~MASK_CORR_GAIN) == 8'h00) && ((lvl_reg & ~MASK_LVL_RESET) == 8'h00))
        else $error("reserved bit set");
    AST_GAIN_WRITE: assert property (
        seq_write_to(ADDR_DIFF_AMP_GAIN) |=> amp_gain_code == $past(shift_reg[1:0]))
        else $error("amplifier gain write lost");
    AST_PHASE_WRITE: assert property (
        seq_write_to(ADDR_PHASE_ADJ_GAIN) |=> phase_gain_step_code == $past(shift_reg[4:0]))
        else $error("phase step write lost");
    AST_CORR_WRITE: assert property (
        seq_write_to(ADDR_CORR_GAIN) |=> correction_gain_code == $past(shift_reg[2:0]))
        else $error("correction gain write lost");
    AST_SHUNT_WRITE: assert property (
        seq_write_to(ADDR_SHUNT_CTRL) |=> (shunt_amp_run == $past(shift_reg[SHUNT_RUN_BIT]))
            && (shunt_ref_source == $past(shift_reg[SHUNT_REF_BIT]))
            && (shunt_gain_code == $past(shift_reg[1:0])))
        else $error("shunt control write lost");
    AST_LVL_RELEASE: assert property (
        seq_write_to(ADDR_LVL_RESET) ##1 (!commit_w)[*2]
            |-> level_detect_rst_n == $past(shift_reg[LVL_RESET_BIT], 2))
        else $error("level detect reset not held");
    AST_BAD_FRAME: assert property (
        seq_bad_end |=> $stable(gain_reg) && $stable(shunt_reg) && $stable(lvl_reg)
            && $stable(phase_reg) && $stable(corr_reg))
        else $error("invalid frame changed a register");
    AST_OVERRUN: assert property (
        (state_reg == SACR_SHIFT) && (cnt_reg == FRAME_BITS) && sclk_rise && !cs_rise
            |=> (state_reg == SACR_ERR) throughout (!cs_rise)[*1])
        else $error("seventeenth clock not rejected");
    AST_SDO_MSB: assert property (
        (state_reg == SACR_SHIFT) && sclk_fall && (cnt_reg == HEADER_BITS) && (rw_reg == RW_READ)
            && !cs_rise |=> sdo == $past(tx_reg[7]))
        else $error("read data msb not driven");
    AST_SDO_QUIET: assert property (
        cs_rise ##1 !cs_fall |-> !sdo_oe)
        else $error("data out driven while deselected");
endmodule : sacr_top

// ### src/sacr_pkg.sv
// constants and types for the serial analog configuration register bank
// ****************************************************************
// Overview of operation
// - two-bit amplifier code selects gain 2, 4, 8 or 16.5 for channels A and B
// - reserved bits read as zero; host writes zero into them
// - five-bit phase adjust code maps directly onto step 0 to 31
// - three-bit correction code selects six gains; host never writes codes 110, 111
// - shunt amplifier control bit 7 stops amplifier at 0, runs it at 1
// - shunt control bit 2 picks internal reference at 0, digital io supply at 1
// - shunt gain code 00 gives 10, 01 gives 25; host avoids 10 and 11
// - level detect bit 0 low holds detection circuit in reset, high releases
// - every register in this group clears to 00h on reset
// - access only over four-wire serial link, host master, device slave
// - each frame is 16 bits: read/write bit, 7-bit address, data byte
// - every frame shifts most significant bit first
// - link is full duplex; device drives data out during host data in
// - any frame not exactly 16 bits is invalid and changes no register
// ****************************************************************
package sacr_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [6:0] ADDR_DIFF_AMP_GAIN  = 7'h2e;
    localparam logic [6:0] ADDR_PHASE_ADJ_GAIN = 7'h30;
    localparam logic [6:0] ADDR_CORR_GAIN      = 7'h36;
    localparam logic [6:0] ADDR_SHUNT_CTRL     = 7'h42;
    localparam logic [6:0] ADDR_LVL_RESET      = 7'h54;

    localparam logic [7:0] REG_RESET_VAL       = 8'h00;
    localparam logic [7:0] MASK_DIFF_AMP_GAIN  = 8'h03;
    localparam logic [7:0] MASK_PHASE_ADJ_GAIN = 8'h1f;
    localparam logic [7:0] MASK_CORR_GAIN      = 8'h07;
    localparam logic [7:0] MASK_SHUNT_CTRL     = 8'h87;
    localparam logic [7:0] MASK_LVL_RESET      = 8'h01;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int SHUNT_RUN_BIT   = 7;
    localparam int SHUNT_REF_BIT   = 2;
    localparam int LVL_RESET_BIT   = 0;

    // ****************************************************************
    // frame format
    // ****************************************************************
    localparam logic [4:0] FRAME_BITS   = 5'h10;
    localparam logic [4:0] HEADER_BITS  = 5'h08;
    localparam logic       RW_READ      = 1'h1;
    localparam int         SYNC_STAGES  = 2;

    // ****************************************************************
    // frame state machine
    // ****************************************************************
    typedef enum logic [2:0] {
        SACR_IDLE  = 3'h1,
        SACR_SHIFT = 3'h2,
        SACR_ERR   = 3'h4
    } sacr_state_e;

endpackage : sacr_pkg

// ### src/sacr_sync.sv
// two-flop synchroniser for asynchronous link pins
`timescale 1ns/1ps
module sacr_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val,
    output logic      [WIDTH-1:0] sync_out
);
    import sacr_pkg::*;

    // ****************************************************************
    // per-bit two-stage chain
    // ****************************************************************
    // stage one feeds only stage two, never any logic
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic [SYNC_STAGES-1:0] chain_reg;
            logic [SYNC_STAGES-1:0] chain_next;
            always_comb begin
                chain_next = {chain_reg[SYNC_STAGES-2:0], async_in[gi]};
            end
            // reset value is a static strap tied at instantiation
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    chain_reg <= '0;
                end else begin
                    chain_reg <= chain_next;
                end
            end
            assign sync_out[gi] = chain_reg[SYNC_STAGES-1] ^ reset_val[gi];
        end
    endgenerate

endmodule : sacr_sync

// ### tb/sacr_host_model.sv
// host side serial master model driving the register link
`timescale 1ns/1ps
module sacr_host_model (
    input  wire logic clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo
);
    // ****************************************************************
    // idle levels
    // ****************************************************************
    // serial clock stands low between frames, mode 0
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    // ****************************************************************
    // frame engine
    // ****************************************************************
    // master frame, msb first
    // bits are shifted from bits[n-1] down; n other than 16 makes a bad frame
    task automatic xfer(input logic [16:0] bits, input int n, output logic [16:0] rx);
        int i;
        rx = '0;
        @(negedge clk);
        cs_n = 1'b0;
        // chip select leads the first rise by more than three clocks
        repeat (4) @(negedge clk);
        for (i = n - 1; i >= 0; i--) begin
            sdi = bits[i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            // sample well after the device has shifted out the bit
            repeat (2) @(negedge clk);
            rx = {rx[15:0], sdo};
            repeat (2) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        // released line shows the inverse so a stale level is never trusted
        sdi = ~sdi;
        // gap covers the commit delay and the minimum deselect time
        repeat (8) @(negedge clk);
    endtask : xfer
endmodule : sacr_host_model

// ### tb/tb_top.sv
// self-checking bench for the serial configuration register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb_top;
    import sacr_pkg::*;

    logic       clk;
    logic       rst_n;
    wire  logic sclk;
    wire  logic cs_n;
    wire  logic sdi;
    logic       sdo;
    logic       sdo_oe;
    logic [1:0] amp_gain_code;
    logic [4:0] phase_gain_step_code;
    logic [2:0] correction_gain_code;
    logic       shunt_amp_run;
    logic       shunt_ref_source;
    logic [1:0] shunt_gain_code;
    logic       level_detect_rst_n;
    int         miscompares;
    int         checks;
    int         cycles;
    int         k;
    logic [7:0] v;
    logic [15:0] w;
    logic [16:0] rx;
    logic [6:0] addrs [5];
    logic [7:0] phs [4];
    logic [7:0] shs [5];
    wire  logic sdo_line;

    // a released data line reads as the inverse, so a stale level is never trusted
    assign sdo_line = sdo_oe ? sdo : ~sdo;

    sacr_top i_dut (
        .clk                  (clk),
        .rst_n                (rst_n),
        .sclk                 (sclk),
        .cs_n                 (cs_n),
        .sdi                  (sdi),
        .sdo                  (sdo),
        .sdo_oe               (sdo_oe),
        .amp_gain_code        (amp_gain_code),
        .phase_gain_step_code (phase_gain_step_code),
        .correction_gain_code (correction_gain_code),
        .shunt_amp_run        (shunt_amp_run),
        .shunt_ref_source     (shunt_ref_source),
        .shunt_gain_code      (shunt_gain_code),
        .level_detect_rst_n   (level_detect_rst_n)
    );

    sacr_host_model i_host (
        .clk  (clk),
        .sclk (sclk),
        .cs_n (cs_n),
        .sdi  (sdi),
        .sdo  (sdo_line)
    );

    // ****************************************************************
    // clock and watchdog
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ceiling sits far above the roughly 7300 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            finish_test();
        end
    end

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [16:0] r;
        i_host.xfer({2'b00, a, d}, 16, r);
    endtask : wr

    // host data byte is nonzero on purpose: a read must ignore it
    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        logic [16:0] r;
        i_host.xfer({2'b01, a, 8'h5a}, 16, r);
        `CHK(r[7:0], exp)
    endtask : rdchk

    task automatic chk_zero();
        `CHK({amp_gain_code, phase_gain_step_code, correction_gain_code, shunt_amp_run,
              shunt_ref_source, shunt_gain_code, level_detect_rst_n}, 15'h0000)
        `CHK(sdo_oe, 1'b0)
    endtask : chk_zero

    task automatic finish_test();
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        miscompares = 0;
        checks      = 0;
        cycles      = 0;
        rst_n       = 1'b0;
        addrs = '{ADDR_DIFF_AMP_GAIN, ADDR_PHASE_ADJ_GAIN, ADDR_CORR_GAIN,
                  ADDR_SHUNT_CTRL, ADDR_LVL_RESET};
        phs   = '{8'h00, 8'h01, 8'h1e, 8'h1f};
        shs   = '{8'h80, 8'h04, 8'h01, 8'h85, 8'h00};
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk_zero();
        for (k = 0; k < 5; k++) rdchk(addrs[k], REG_RESET_VAL);
        for (k = 0; k < 4; k++) begin
            v = k[7:0];
            wr(ADDR_DIFF_AMP_GAIN, v);
            `CHK(amp_gain_code, v[1:0])
            rdchk(ADDR_DIFF_AMP_GAIN, v);
        end
        for (k = 0; k < 4; k++) begin
            wr(ADDR_PHASE_ADJ_GAIN, phs[k]);
            `CHK(phase_gain_step_code, phs[k][4:0])
            rdchk(ADDR_PHASE_ADJ_GAIN, phs[k]);
        end
        // only the six legal correction codes are written
        for (k = 0; k < 6; k++) begin
            v = k[7:0];
            wr(ADDR_CORR_GAIN, v);
            `CHK(correction_gain_code, v[2:0])
        end
        // shunt gain stays at the two legal codes
        for (k = 0; k < 5; k++) begin
            wr(ADDR_SHUNT_CTRL, shs[k]);
            `CHK(shunt_amp_run, shs[k][SHUNT_RUN_BIT])
            `CHK(shunt_ref_source, shs[k][SHUNT_REF_BIT])
            `CHK(shunt_gain_code, shs[k][1:0])
            rdchk(ADDR_SHUNT_CTRL, shs[k]);
        end
        // restart of level detection: one then zero
        wr(ADDR_LVL_RESET, 8'h01);
        `CHK(level_detect_rst_n, 1'b1)
        rdchk(ADDR_LVL_RESET, 8'h01);
        wr(ADDR_LVL_RESET, 8'h00);
        `CHK(level_detect_rst_n, 1'b0)
        // ones into reserved places on purpose, they must read back as zero
        wr(ADDR_DIFF_AMP_GAIN, 8'hff);
        rdchk(ADDR_DIFF_AMP_GAIN, MASK_DIFF_AMP_GAIN);
        wr(ADDR_SHUNT_CTRL, 8'h85);
        // short frame, early deselect, then an overlong frame
        w = {1'b0, ADDR_DIFF_AMP_GAIN, 8'h01};
        i_host.xfer({2'b00, w[15:1]}, 15, rx);
        `CHK(amp_gain_code, 2'b11)
        i_host.xfer({w, 1'b0}, 17, rx);
        `CHK(amp_gain_code, 2'b11)
        rdchk(ADDR_DIFF_AMP_GAIN, 8'h03);
        // unmapped address, then reads leave the registers alone
        wr(7'h2f, 8'hff);
        rdchk(7'h2f, 8'h00);
        rdchk(ADDR_SHUNT_CTRL, 8'h85);
        `CHK({shunt_amp_run, shunt_ref_source, shunt_gain_code}, 4'hd)
        `CHK(sdo_oe, 1'b0)
        // second reset in mid-run clears the bank again
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk_zero();
        rdchk(ADDR_SHUNT_CTRL, REG_RESET_VAL);
        finish_test();
    end
endmodule : tb_top
